/* File: hw/pde_pkg.sv */
// Purpose: constants for the port direction enable block
// Assumes: byte-wide registers, one per aligned APB word
// Notes: offsets are register indices; byte address is four times the index
package pde_pkg;
  localparam int IDX_W = 14;
  localparam int REG_W = 8;
  localparam int ADDR_MIN_W = 16; // index 0x30BA needs paddr[15:2]
  // register indices
  localparam logic [IDX_W-1:0] IDX_A_DATA = 14'h0000;
  localparam logic [IDX_W-1:0] IDX_B_DATA = 14'h0001;
  localparam logic [IDX_W-1:0] IDX_C_DATA = 14'h0002;
  localparam logic [IDX_W-1:0] IDX_A_OE = 14'h30B0;
  localparam logic [IDX_W-1:0] IDX_B_OE = 14'h30B1;
  localparam logic [IDX_W-1:0] IDX_C_OE = 14'h30B2;
  localparam logic [IDX_W-1:0] IDX_A_IE = 14'h30B8;
  localparam logic [IDX_W-1:0] IDX_B_IE = 14'h30B9;
  localparam logic [IDX_W-1:0] IDX_C_IE = 14'h30BA;
  // writable bit masks; reserved positions are zero
  localparam logic [REG_W-1:0] MASK_A_DATA = 8'h3F;
  localparam logic [REG_W-1:0] MASK_A_OE = 8'h3F;
  localparam logic [REG_W-1:0] MASK_A_IE = 8'h2F;
  localparam logic [REG_W-1:0] MASK_B = 8'hFF;
  localparam logic [REG_W-1:0] MASK_C = 8'h0F;
  localparam logic [REG_W-1:0] RESET_VAL = 8'h00;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;
endpackage : pde_pkg

/* File: hw/pde_top.sv */
// Purpose: per-pin output and input enables for ports A, B and C
// Assumes: APB slave, zero wait states, core_clk at 125 MHz
// Notes: pin inputs pass a two-stage synchroniser before use
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - each port B pin has a rw output enable bit, 1 drives
// - port C pins 3..0 have rw output enables; bits 7..4 reserved
// - port A input enables on pins 5,3,2,1,0; bits 7..6, 4 reserved
// - each port B pin 7..0 has a rw input enable bit
// - reserved bits ignore writes and always read zero
// - input path is gated off when its enable is 0, whatever output
// - data read: pin level for inputs, latch for outputs
// - reset clears data latches and leaves every pin high impedance
module pde_top #(
  parameter int ADDR_W = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] port_a_pin_in,
  output logic [5:0] port_a_pin_out,
  output logic [5:0] port_a_pin_oe,
  input wire logic [7:0] port_b_pin_in,
  output logic [7:0] port_b_pin_out,
  output logic [7:0] port_b_pin_oe,
  input wire logic [3:0] port_c_pin_in,
  output logic [3:0] port_c_pin_out,
  output logic [3:0] port_c_pin_oe,
  output logic [5:0] port_a_input,
  output logic [7:0] port_b_input,
  output logic [3:0] port_c_input
);
  // refuse an address bus too narrow to reach the enable registers
  if (ADDR_W < pde_pkg::ADDR_MIN_W) begin : g_bad_addr
    $error("pde_top: ADDR_W too small for the register map");
  end

  logic [7:0] a_data_reg, a_data_next, b_data_reg, b_data_next;
  logic [7:0] c_data_reg, c_data_next;
  logic [7:0] port_a_output_enable_reg, port_a_output_enable_next;
  logic [7:0] port_b_output_enable_reg, port_b_output_enable_next;
  logic [7:0] port_c_output_enable_reg, port_c_output_enable_next;
  logic [7:0] port_a_input_enable_reg, port_a_input_enable_next;
  logic [7:0] port_b_input_enable_reg, port_b_input_enable_next;
  logic [7:0] port_c_input_enable_reg, port_c_input_enable_next;
  logic [17:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic [17:0] gated_reg, gated_next;
  logic [31:0] prdata_reg, prdata_next;
  logic slverr_reg, slverr_next;
  logic [pde_pkg::IDX_W-1:0] idx;
  logic upper_zero, wr_en;
  logic [7:0] wbyte, rd_val;
  logic [7:0] a_sync, b_sync, c_sync;
  logic hit;

  // word index; any address bit above the map makes the access unmapped
  assign idx = paddr[pde_pkg::IDX_W+1:2];
  assign upper_zero = (paddr >> (pde_pkg::IDX_W + 2)) == '0;
  assign wbyte = pwdata[7:0];
  // write lands only in the access phase, lane 0 strobed, mapped address
  assign wr_en = psel && penable && pwrite && pstrb[0] && !slverr_reg;
  assign a_sync = {2'h0, sync2_reg[5:0]};
  assign b_sync = sync2_reg[13:6];
  assign c_sync = {4'h0, sync2_reg[17:14]};

  // read mux: output pins show the latch, input pins the gated level
  // pins with both enables 0 read zero; a fixed value keeps software tests repeatable
  // a pin with both enables set reads the latch, not the pad level
  function automatic logic [7:0] pin_view(input logic [7:0] oe,
      input logic [7:0] ie, input logic [7:0] dat, input logic [7:0] lvl);
    pin_view = (oe & dat) | (~oe & ie & lvl);
  endfunction : pin_view

  // setup-phase decode captures read data and error ahead of the access
  // capturing at setup keeps prdata a flop output with zero wait states;
  // the price is that a pin change in the access cycle is not seen
  always_comb begin
    hit = upper_zero;
    rd_val = 8'h00;
    case (idx)
      pde_pkg::IDX_A_DATA: rd_val = pin_view(port_a_output_enable_reg,
          port_a_input_enable_reg, a_data_reg, a_sync);
      pde_pkg::IDX_B_DATA: rd_val = pin_view(port_b_output_enable_reg,
          port_b_input_enable_reg, b_data_reg, b_sync);
      pde_pkg::IDX_C_DATA: rd_val = pin_view(port_c_output_enable_reg,
          port_c_input_enable_reg, c_data_reg, c_sync);
      pde_pkg::IDX_A_OE: rd_val = port_a_output_enable_reg;
      pde_pkg::IDX_B_OE: rd_val = port_b_output_enable_reg;
      pde_pkg::IDX_C_OE: rd_val = port_c_output_enable_reg;
      pde_pkg::IDX_A_IE: rd_val = port_a_input_enable_reg;
      pde_pkg::IDX_B_IE: rd_val = port_b_input_enable_reg;
      pde_pkg::IDX_C_IE: rd_val = port_c_input_enable_reg;
      default: hit = 1'b0;
    endcase
    prdata_next = prdata_reg;
    slverr_next = slverr_reg;
    if (psel && !penable) begin
      prdata_next = hit ? {24'h000000, rd_val} : pde_pkg::RDATA_ZERO;
      slverr_next = !hit;
    end
  end

  // register writes; masks keep reserved bits at zero
  // data latches take writes whatever the direction, so software can
  // preload a level before it turns the driver on
  always_comb begin
    a_data_next = a_data_reg;
    b_data_next = b_data_reg;
    c_data_next = c_data_reg;
    port_a_output_enable_next = port_a_output_enable_reg;
    port_b_output_enable_next = port_b_output_enable_reg;
    port_c_output_enable_next = port_c_output_enable_reg;
    port_a_input_enable_next = port_a_input_enable_reg;
    port_b_input_enable_next = port_b_input_enable_reg;
    port_c_input_enable_next = port_c_input_enable_reg;
    if (wr_en) begin
      case (idx)
        pde_pkg::IDX_A_DATA: a_data_next = wbyte & pde_pkg::MASK_A_DATA;
        pde_pkg::IDX_B_DATA: b_data_next = wbyte & pde_pkg::MASK_B;
        pde_pkg::IDX_C_DATA: c_data_next = wbyte & pde_pkg::MASK_C;
        pde_pkg::IDX_A_OE:
          port_a_output_enable_next = wbyte & pde_pkg::MASK_A_OE;
        pde_pkg::IDX_B_OE:
          port_b_output_enable_next = wbyte & pde_pkg::MASK_B;
        pde_pkg::IDX_C_OE:
          port_c_output_enable_next = wbyte & pde_pkg::MASK_C;
        pde_pkg::IDX_A_IE:
          port_a_input_enable_next = wbyte & pde_pkg::MASK_A_IE;
        pde_pkg::IDX_B_IE:
          port_b_input_enable_next = wbyte & pde_pkg::MASK_B;
        pde_pkg::IDX_C_IE:
          port_c_input_enable_next = wbyte & pde_pkg::MASK_C;
        default: ;
      endcase
    end
  end

  // pin synchroniser and gated inputs; ie alone decides the path
  // only sync2 is read by logic; sync1 may still be metastable
  always_comb begin
    sync1_next = {port_c_pin_in, port_b_pin_in, port_a_pin_in};
    sync2_next = sync1_reg;
    gated_next = sync2_reg & {port_c_input_enable_reg[3:0],
        port_b_input_enable_reg, port_a_input_enable_reg[5:0]};
  end

  // bus response flops; cleared so no stale error follows a reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata_reg <= pde_pkg::RDATA_ZERO;
      slverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      slverr_reg <= slverr_next;
    end
  end

  // every latch and enable zero on reset: all pins high impedance
  // zero latches are not driven out because the oe bits clear with them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      a_data_reg <= pde_pkg::RESET_VAL;
      b_data_reg <= pde_pkg::RESET_VAL;
      c_data_reg <= pde_pkg::RESET_VAL;
      port_a_output_enable_reg <= pde_pkg::RESET_VAL;
      port_b_output_enable_reg <= pde_pkg::RESET_VAL;
      port_c_output_enable_reg <= pde_pkg::RESET_VAL;
      port_a_input_enable_reg <= pde_pkg::RESET_VAL;
      port_b_input_enable_reg <= pde_pkg::RESET_VAL;
      port_c_input_enable_reg <= pde_pkg::RESET_VAL;
    end else begin
      a_data_reg <= a_data_next;
      b_data_reg <= b_data_next;
      c_data_reg <= c_data_next;
      port_a_output_enable_reg <= port_a_output_enable_next;
      port_b_output_enable_reg <= port_b_output_enable_next;
      port_c_output_enable_reg <= port_c_output_enable_next;
      port_a_input_enable_reg <= port_a_input_enable_next;
      port_b_input_enable_reg <= port_b_input_enable_next;
      port_c_input_enable_reg <= port_c_input_enable_next;
    end
  end

  // synchroniser flops; cleared so inputs read zero until pins settle
  // costs two extra edges of input latency after a reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      gated_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      gated_reg <= gated_next;
    end
  end

  // drivers follow the oe bits; latch value sits on out either way
  assign port_a_pin_out = a_data_reg[5:0];
  assign port_b_pin_out = b_data_reg;
  assign port_c_pin_out = c_data_reg[3:0];
  assign port_a_pin_oe = port_a_output_enable_reg[5:0];
  assign port_b_pin_oe = port_b_output_enable_reg;
  assign port_c_pin_oe = port_c_output_enable_reg[3:0];
  assign port_a_input = gated_reg[5:0];
  assign port_b_input = gated_reg[13:6];
  assign port_c_input = gated_reg[17:14];
  // bus handshake: error shows only while the access phase stands
  assign prdata = prdata_reg;
  assign pslverr = slverr_reg && psel && penable;
  assign pready = 1'b1; // zero wait states
endmodule : pde_top

`default_nettype wire

/* File: test/pde_top_props.sv */
// Purpose: assertions on the port direction enable block
// Assumes: zero wait state APB, byte address is four times the index
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module pde_top_props #(parameter int ADDR_W = 16) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic [5:0] port_a_input,
  input wire logic [7:0] port_b_pin_out,
  input wire logic [7:0] port_b_pin_oe,
  input wire logic [3:0] port_c_pin_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic wr, rd;
  // write access edge and read setup edge; read data is captured at setup
  assign wr = psel && penable && pwrite && pstrb[0];
  assign rd = psel && !penable && !pwrite;
  a_b_oe_write: assert property (wr && paddr == 16'hC2C4 |=>
    port_b_pin_oe == $past(pwdata[7:0])) else $error("b oe write");
  a_b_oe_read: assert property (rd && paddr == 16'hC2C4 |=>
    prdata[7:0] == $past(port_b_pin_oe)) else $error("b oe read");
  a_c_oe_write: assert property (wr && paddr == 16'hC2C8 |=>
    port_c_pin_oe == $past(pwdata[3:0])) else $error("c oe write");
  a_a_ie_rsvd: assert property (rd && paddr == 16'hC2E0 |=>
    prdata[7:6] == 2'h0 && !prdata[4]) else $error("a ie reserved");
  a_a4_gated: assert property (!port_a_input[4])
    else $error("pin a4 input open");
  a_upper_zero: assert property (psel && penable |->
    prdata[31:8] == 24'h0) else $error("upper read bits");
  a_out_readback: assert property (rd && paddr == 16'h0004 |=>
    ((prdata[7:0] ^ $past(port_b_pin_out)) & $past(port_b_pin_oe)) == 8'h0)
    else $error("driven pin readback");
  a_reset_hiz: assert property ($fell(reset) |->
    port_b_pin_oe == 8'h0 && port_c_pin_oe == 4'h0 && port_b_pin_out == 8'h0)
    else $error("pins driven after reset");
endmodule : pde_top_props
bind pde_top pde_top_props #(.ADDR_W(ADDR_W)) u_props (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .port_a_input(port_a_input),
  .port_b_pin_out(port_b_pin_out), .port_b_pin_oe(port_b_pin_oe),
  .port_c_pin_oe(port_c_pin_oe));
`default_nettype wire

/* File: test/pde_pin_model.sv */
// Purpose: outside circuitry on the pins of one port
// Assumes: no pullups; the outside level is chosen by the bench
// Notes: where the block drives, it wins over the outside level
`timescale 1ns/1ps
`default_nettype none
module pde_pin_model #(parameter int W = 8) (
  input wire logic [W-1:0] o,
  input wire logic [W-1:0] e,
  input wire logic [W-1:0] x,
  output logic [W-1:0] i
);
  // resolved wire level fed back to the pin input
  assign i = (e & o) | (~e & x);
endmodule : pde_pin_model
`default_nettype wire

/* File: test/pde_top_tb.sv */
// Purpose: self-checking bench for the port direction enable block
// Assumes: pready high at the access edge, reads of pins with both enables off give 0
// Notes: register rows first, then pin, refusal and reset cases
`timescale 1ns/1ps
`default_nettype none
module pde_top_tb;
  logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, e;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'hF, c_in, c_out, c_oe, c_x = 4'h0, port_c_input;
  logic pready, pslverr;
  logic [5:0] a_in, a_out, a_oe, a_x = 6'h0, port_a_input;
  logic [7:0] b_in, b_out, b_oe, b_x = 8'h0, port_b_input;
  int failures = 0, num_checks = 0;
  // rows: byte address, value written, value read back
  logic [15:0] ra [6] = '{16'hC2C0, 16'hC2C4, 16'hC2C8, 16'hC2E0, 16'hC2E4,
    16'hC2E8};
  logic [7:0] rw [6] = '{8'hFF, 8'hA5, 8'hFF, 8'hFF, 8'h5A, 8'hFF};
  logic [7:0] rx [6] = '{8'h3F, 8'hA5, 8'h0F, 8'h2F, 8'h5A, 8'h0F};
  pde_top DUT (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_pin_in(a_in), .port_a_pin_out(a_out), .port_a_pin_oe(a_oe),
    .port_b_pin_in(b_in), .port_b_pin_out(b_out), .port_b_pin_oe(b_oe),
    .port_c_pin_in(c_in), .port_c_pin_out(c_out), .port_c_pin_oe(c_oe),
    .port_a_input(port_a_input), .port_b_input(port_b_input),
    .port_c_input(port_c_input));
  pde_pin_model #(.W(6)) u_pa (.o(a_out), .e(a_oe), .x(a_x), .i(a_in));
  pde_pin_model #(.W(8)) u_pb (.o(b_out), .e(b_oe), .x(b_x), .i(b_in));
  pde_pin_model #(.W(4)) u_pc (.o(c_out), .e(c_oe), .x(c_x), .i(c_in));
  // 125 MHz clock; watchdog at 5000 cycles, far beyond the hundred or so needed
  initial forever #4 core_clk = ~core_clk;
  initial begin
    #40000;
    failures++;
    test_done();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one APB transfer; request held until pready is seen at an access edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ra[i], rw[i]);
      apb(1'b0, ra[i], 8'h00);
      chk(r, {24'h0, rx[i]});
    end
    chk(32'({a_oe, b_oe, c_oe}), {14'h0, 6'h3F, 8'hA5, 4'hF});
    // port A driven high: pin a4 has no input enable to pass its level
    apb(1'b1, 16'h0000, 8'hFF);
    apb(1'b1, 16'h0008, 8'hFA);
    repeat (4) @(posedge core_clk);
    apb(1'b0, 16'h0000, 8'h00);
    chk(r, 32'h3F);
    chk(32'({port_a_input, c_out}), {22'h0, 6'h2F, 4'hA});
    // port C released: its data register reads the outside level
    c_x <= 4'h5;
    apb(1'b1, 16'hC2C8, 8'h00);
    repeat (4) @(posedge core_clk);
    apb(1'b0, 16'h0008, 8'h00);
    chk(r, 32'h5);
    chk({28'h0, port_c_input}, 32'h5);
    // mixed directions: driven pins read the latch, inputs read the pin
    b_x <= 8'hF0;
    apb(1'b1, 16'h0004, 8'h3C);
    repeat (4) @(posedge core_clk);
    apb(1'b0, 16'h0004, 8'h00);
    chk(r, {24'h0, (8'h3C & 8'hA5) | (8'hF0 & 8'h5A)});
    chk({24'h0, port_b_input}, {24'h0, 8'hF0 & 8'h5A});
    // input enables off: even driven pins must not reach the core
    apb(1'b1, 16'hC2E4, 8'h00);
    repeat (4) @(posedge core_clk);
    apb(1'b0, 16'h0004, 8'h00);
    chk(r, {24'h0, 8'h3C & 8'hA5});
    chk({24'h0, port_b_input}, 32'h0);
    // cleared strobe is ignored; unmapped access errors with zero data
    pstrb <= 4'h0;
    apb(1'b1, 16'hC2C4, 8'h00);
    pstrb <= 4'hF;
    apb(1'b0, 16'hC2C4, 8'h00);
    chk(r, 32'hA5);
    apb(1'b0, 16'h0010, 8'h00);
    chk({r[30:0], e}, 32'h1);
    // reset in mid-run releases every pin
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk(32'({a_oe, b_oe, c_oe, a_out, b_out}), 32'h0);
    chk(32'({port_a_input, port_c_input, c_out}), 32'h0);
    test_done();
  end
endmodule : pde_top_tb
`default_nettype wire
